// ==== design/rtc_flags_pkg.sv ====
package rtc_flags_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [ADDR_W-1:0] FLAG_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h1;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 4'h2;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 4'h3;
  localparam logic [ADDR_W-1:0] PIN_STATE_ADDR = 4'h4;

  ////////////////////////////////////////////////////////////////////////////
  // field positions, shared by flag, status and mask registers, plus the control level select
  localparam int COMP_STOP_BIT = 0;
  localparam int DATA_LOSS_BIT = 1;
  localparam int EXT_EVENT_BIT = 2;
  localparam int LEVEL_SEL_BIT = 0;
  localparam int FLAG_COUNT = 3;

  ////////////////////////////////////////////////////////////////////////////
  // synchroniser lanes
  localparam int PIN_COUNT = 3;
  localparam int EVENT_LANE = 0;
  localparam int LOW2_LANE = 1;
  localparam int LOW1_LANE = 2;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic LEVEL_SEL_RESET = 1'h0;
  localparam logic DATA_LOSS_RESET = 1'h1;
  localparam logic COMP_STOP_RESET = 1'h1;
  localparam logic EXT_EVENT_RESET = 1'h0;
  localparam logic [FLAG_COUNT-1:0] MASK_RESET = 3'h0;
  localparam logic [FLAG_COUNT-1:0] STATUS_RESET = 3'h0;
  localparam logic [DATA_W-1:0] RDATA_RESET = 8'h00;
  localparam logic [PIN_COUNT-1:0] SYNC_RESET = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // power-on capture waits for the synchroniser to fill
  localparam int INIT_W = 2;
  localparam logic [INIT_W-1:0] INIT_RESET = 2'h0;
  localparam logic [INIT_W-1:0] INIT_STEP = 2'h1;
  localparam logic [INIT_W-1:0] SYNC_STAGES = 2'h2;

endpackage

// ==== design/pin_sync.sv ====
`timescale 1ns/10ps
module pin_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // asynchronous pins in, settled levels out
  input wire logic [rtc_flags_pkg::PIN_COUNT-1:0] pin_async,
  output logic [rtc_flags_pkg::PIN_COUNT-1:0] pin_level
);

  typedef struct packed {
    logic [rtc_flags_pkg::PIN_COUNT-1:0] stage1;
    logic [rtc_flags_pkg::PIN_COUNT-1:0] stage2;
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  // first stage feeds only the second stage
  always_comb begin
    next_state = state;
    next_state.stage1 = pin_async;
    next_state.stage2 = state.stage1;
  end

  // two flops per lane
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= '{stage1: rtc_flags_pkg::SYNC_RESET, stage2: rtc_flags_pkg::SYNC_RESET};
    end else begin
      state <= next_state;
    end
  end

  assign pin_level = state.stage2;

endmodule

// ==== design/rtc_event_voltage_flags.sv ====
`timescale 1ns/10ps
module rtc_event_voltage_flags (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire logic [rtc_flags_pkg::ADDR_W-1:0] addr,
  input wire logic [rtc_flags_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [rtc_flags_pkg::DATA_W-1:0] rdata,
  // event and supply monitor pins
  input wire logic event_input_pin,
  input wire logic second_low_voltage_threshold,
  input wire logic first_low_voltage_threshold,
  // flag levels
  output logic external_event_flag,
  output logic data_loss_voltage_flag,
  output logic compensation_stop_voltage_flag,
  output logic init_done,
  // interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [rtc_flags_pkg::DATA_W-1:0] rdata;
    logic irq;
    logic ext_event;
    logic data_loss;
    logic comp_stop;
    logic level_sel;
    logic [rtc_flags_pkg::FLAG_COUNT-1:0] mask;
    logic [rtc_flags_pkg::FLAG_COUNT-1:0] status;
    logic event_prev;
    logic low2_prev;
    logic low1_prev;
    logic [rtc_flags_pkg::INIT_W-1:0] init_cnt;
    logic init_done;
  } flags_state_t;

  flags_state_t state;
  flags_state_t next_state;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  logic [rtc_flags_pkg::PIN_COUNT-1:0] pin_raw;
  logic [rtc_flags_pkg::PIN_COUNT-1:0] pin_level;

  // lane order follows the package lane indices
  assign pin_raw = {first_low_voltage_threshold, second_low_voltage_threshold,
                    event_input_pin};

  pin_sync u_pin_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_async(pin_raw),
    .pin_level(pin_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // a flag write clears a bit when the written bit is zero
  function automatic logic clear_request(
    input logic strobe,
    input logic [rtc_flags_pkg::DATA_W-1:0] data,
    input int pos
  );
    clear_request = strobe && !data[pos];
  endfunction

  // event pin is active when it matches the selected level
  function automatic logic event_active(input logic pin, input logic sel);
    event_active = (pin == sel);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decoded strobes and events

  logic flag_wr;
  logic ctrl_wr;
  logic status_wr;
  logic mask_wr;
  logic clr_data_loss;
  logic clr_comp_stop;
  logic clr_voltage;
  logic clr_event;
  logic event_now;
  logic event_set;
  logic low2_set;
  logic low1_set;
  logic [rtc_flags_pkg::FLAG_COUNT-1:0] flag_rise;
  logic [rtc_flags_pkg::FLAG_COUNT-1:0] flags_now;
  logic [rtc_flags_pkg::DATA_W-1:0] read_value;

  // address decode for writes
  always_comb begin
    flag_wr = 1'b0;
    ctrl_wr = 1'b0;
    status_wr = 1'b0;
    mask_wr = 1'b0;
    if (wr && addr == rtc_flags_pkg::FLAG_ADDR) begin
      flag_wr = 1'b1;
    end else if (wr && addr == rtc_flags_pkg::CTRL_ADDR) begin
      ctrl_wr = 1'b1;
    end else if (wr && addr == rtc_flags_pkg::IRQ_STATUS_ADDR) begin
      status_wr = 1'b1;
    end else if (wr && addr == rtc_flags_pkg::IRQ_MASK_ADDR) begin
      mask_wr = 1'b1;
    end
  end

  // clear requests from a flag write; a zero in either voltage bit clears both voltage flags
  // write one ignored
  assign clr_data_loss = clear_request(flag_wr, wdata, rtc_flags_pkg::DATA_LOSS_BIT);
  assign clr_comp_stop = clear_request(flag_wr, wdata, rtc_flags_pkg::COMP_STOP_BIT);
  assign clr_voltage = clr_data_loss || clr_comp_stop;
  assign clr_event = clear_request(flag_wr, wdata, rtc_flags_pkg::EXT_EVENT_BIT);

  // event detection on the settled pin, only after the power-on capture
  assign event_now = event_active(pin_level[rtc_flags_pkg::EVENT_LANE], state.level_sel);
  assign event_set = state.init_done && event_now && !state.event_prev;
  assign low2_set = state.init_done && pin_level[rtc_flags_pkg::LOW2_LANE] && !state.low2_prev;
  assign low1_set = state.init_done && pin_level[rtc_flags_pkg::LOW1_LANE] && !state.low1_prev;

  // flag view in register layout
  always_comb begin
    flags_now = '0;
    flags_now[rtc_flags_pkg::EXT_EVENT_BIT] = state.ext_event;
    flags_now[rtc_flags_pkg::DATA_LOSS_BIT] = state.data_loss;
    flags_now[rtc_flags_pkg::COMP_STOP_BIT] = state.comp_stop;
  end

  // one interrupt event per flag that a pin edge takes from clear to set
  always_comb begin
    flag_rise = '0;
    flag_rise[rtc_flags_pkg::EXT_EVENT_BIT] = event_set && !state.ext_event;
    flag_rise[rtc_flags_pkg::DATA_LOSS_BIT] = low2_set && !state.data_loss;
    flag_rise[rtc_flags_pkg::COMP_STOP_BIT] = low1_set && !state.comp_stop;
  end

  // read multiplexer; unmapped addresses read zero
  always_comb begin
    read_value = '0;
    if (addr == rtc_flags_pkg::FLAG_ADDR) begin
      read_value[rtc_flags_pkg::FLAG_COUNT-1:0] = flags_now;
    end else if (addr == rtc_flags_pkg::CTRL_ADDR) begin
      read_value[rtc_flags_pkg::LEVEL_SEL_BIT] = state.level_sel;
    end else if (addr == rtc_flags_pkg::IRQ_STATUS_ADDR) begin
      read_value[rtc_flags_pkg::FLAG_COUNT-1:0] = state.status;
    end else if (addr == rtc_flags_pkg::IRQ_MASK_ADDR) begin
      read_value[rtc_flags_pkg::FLAG_COUNT-1:0] = state.mask;
    end else if (addr == rtc_flags_pkg::PIN_STATE_ADDR) begin
      read_value[rtc_flags_pkg::PIN_COUNT-1:0] = pin_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_state = state;

    // read data stands for one cycle only
    next_state.rdata = rd ? read_value : rtc_flags_pkg::RDATA_RESET;

    // control and mask registers
    if (ctrl_wr) begin
      next_state.level_sel = wdata[rtc_flags_pkg::LEVEL_SEL_BIT];
    end
    if (mask_wr) begin
      next_state.mask = wdata[rtc_flags_pkg::FLAG_COUNT-1:0];
    end

    // edge history follows the settled pins
    next_state.event_prev = event_now;
    next_state.low2_prev = pin_level[rtc_flags_pkg::LOW2_LANE];
    next_state.low1_prev = pin_level[rtc_flags_pkg::LOW1_LANE];

    // power-on capture once the synchroniser holds the real pin level
    if (!state.init_done) begin
      if (state.init_cnt == rtc_flags_pkg::SYNC_STAGES) begin
        next_state.init_done = 1'b1;
        next_state.ext_event = event_now;
      end else begin
        next_state.init_cnt = state.init_cnt + rtc_flags_pkg::INIT_STEP;
      end
    end else begin
      if (clr_event) begin
        next_state.ext_event = 1'b0;
      end
      if (event_set) begin
        next_state.ext_event = 1'b1;
      end
    end

    if (clr_voltage) begin
      next_state.data_loss = 1'b0;
      next_state.comp_stop = 1'b0;
    end
    if (low2_set) begin
      next_state.data_loss = 1'b1;
    end
    if (low1_set) begin
      next_state.comp_stop = 1'b1;
    end

    // sticky status, write one clears, a new event wins
    if (status_wr) begin
      next_state.status = state.status & ~wdata[rtc_flags_pkg::FLAG_COUNT-1:0];
    end
    next_state.status = next_state.status | flag_rise;

    // interrupt level from the registered status and mask
    next_state.irq = |(state.status & state.mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state.rdata <= rtc_flags_pkg::RDATA_RESET;
      state.irq <= 1'b0;
      state.ext_event <= rtc_flags_pkg::EXT_EVENT_RESET;
      state.data_loss <= rtc_flags_pkg::DATA_LOSS_RESET;
      state.comp_stop <= rtc_flags_pkg::COMP_STOP_RESET;
      state.level_sel <= rtc_flags_pkg::LEVEL_SEL_RESET;
      state.mask <= rtc_flags_pkg::MASK_RESET;
      state.status <= rtc_flags_pkg::STATUS_RESET;
      state.event_prev <= 1'b0;
      state.low2_prev <= 1'b0;
      state.low1_prev <= 1'b0;
      state.init_cnt <= rtc_flags_pkg::INIT_RESET;
      state.init_done <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flops

  assign rdata = state.rdata;
  assign irq = state.irq;
  assign external_event_flag = state.ext_event;
  assign data_loss_voltage_flag = state.data_loss;
  assign compensation_stop_voltage_flag = state.comp_stop;
  assign init_done = state.init_done;

endmodule

// ==== verification/rtc_flags_asserts.sv ====
`timescale 1ns/10ps
module rtc_flags_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire logic [rtc_flags_pkg::ADDR_W-1:0] addr,
  input wire logic [rtc_flags_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [rtc_flags_pkg::DATA_W-1:0] rdata,
  // pins
  input wire logic event_input_pin,
  input wire logic second_low_voltage_threshold,
  input wire logic first_low_voltage_threshold,
  // flags and interrupt
  input wire logic external_event_flag,
  input wire logic data_loss_voltage_flag,
  input wire logic compensation_stop_voltage_flag,
  input wire logic init_done,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // helpers: flag write, quiet supply, tracked level select
  wire logic wf = wr && addr == rtc_flags_pkg::FLAG_ADDR;
  wire logic quiet = !second_low_voltage_threshold && !first_low_voltage_threshold;
  logic sel;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel <= 1'h0;
    end else if (wr && addr == rtc_flags_pkg::CTRL_ADDR) begin
      sel <= wdata[0];
    end
  end

  // event and threshold steps, held long enough to pass the synchroniser
  sequence ev_fall;
    $fell(event_input_pin) && !sel && init_done ##1 !event_input_pin [*3];
  endsequence
  sequence low2_rise;
    $rose(second_low_voltage_threshold) && init_done ##1 second_low_voltage_threshold [*3];
  endsequence
  sequence calm;
    quiet [*4];
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  chk_por_event: assert property (
    $rose(init_done) |-> external_event_flag == !event_input_pin) else $error("event capture");
  chk_por_voltage: assert property (
    $rose(rst_n) |-> data_loss_voltage_flag && compensation_stop_voltage_flag)
    else $error("voltage flags not set by reset");
  chk_ev_hold: assert property (
    external_event_flag && !(wf && !wdata[2]) |=> external_event_flag) else $error("event lost");
  chk_ev_set: assert property (
    ev_fall |=> external_event_flag) else $error("event not flagged");
  chk_dl_set: assert property (
    low2_rise |=> data_loss_voltage_flag) else $error("data loss not flagged");
  chk_dl_hold: assert property (
    data_loss_voltage_flag && !(wf && !(wdata[1] && wdata[0])) |=> data_loss_voltage_flag)
    else $error("data loss dropped");
  chk_dl_clear: assert property (
    calm ##0 (wf && !wdata[1]) |=> !data_loss_voltage_flag && !compensation_stop_voltage_flag)
    else $error("data loss clear");
  chk_cs_clear: assert property (
    calm ##0 (wf && !wdata[0]) |=> !data_loss_voltage_flag && !compensation_stop_voltage_flag)
    else $error("comp stop clear");
  chk_flag_read: assert property (
    $past(rd && addr == rtc_flags_pkg::FLAG_ADDR) |-> rdata[2:0] == $past({external_event_flag,
    data_loss_voltage_flag, compensation_stop_voltage_flag})) else $error("flag read");
endmodule

// ==== verification/rtc_event_voltage_flags_test.sv ====
`timescale 1ns/10ps
module rtc_event_voltage_flags_test;
  typedef struct packed {logic w; logic [3:0] a; logic [7:0] d;} row_t;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic event_input_pin = 1'h1;
  logic second_low_voltage_threshold = 1'h0;
  logic first_low_voltage_threshold = 1'h0;
  logic [7:0] rdata;
  logic external_event_flag, data_loss_voltage_flag, compensation_stop_voltage_flag;
  logic init_done, irq;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  // write rows carry data, read rows carry the expected value
  row_t rows [12] = '{
    '{1'h0, 4'h0, 8'h03}, '{1'h1, 4'h0, 8'h07}, '{1'h0, 4'h0, 8'h03},
    '{1'h1, 4'h0, 8'h05}, '{1'h0, 4'h0, 8'h00}, '{1'h0, 4'h1, 8'h00},
    '{1'h0, 4'h2, 8'h00}, '{1'h0, 4'h3, 8'h00}, '{1'h0, 4'hF, 8'h00},
    '{1'h1, 4'h3, 8'h07}, '{1'h0, 4'h3, 8'h07}, '{1'h0, 4'h4, 8'h01}};

  rtc_event_voltage_flags uut (.clk_sys, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
    .event_input_pin, .second_low_voltage_threshold, .first_low_voltage_threshold,
    .external_event_flag, .data_loss_voltage_flag, .compensation_stop_voltage_flag,
    .init_done, .irq);

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      conclude;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus and check tasks
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'h0;
  endtask
  task automatic get(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'h0;
    #1;
    check($sformatf("reg %h", a), exp, rdata);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic por(input logic pin);
    rst_n <= 1'h0;
    event_input_pin <= pin;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'h1;
    idle(5);
    check("init_done", 8'h01, {7'h00, init_done});
  endtask
  task automatic conclude;
    $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    por(1'h1);
    foreach (rows[i]) begin
      if (rows[i].w) begin
        put(rows[i].a, rows[i].d);
      end else begin
        get(rows[i].a, rows[i].d);
      end
    end
    $display("test register rows done");
    event_input_pin <= 1'h0;
    idle(6);
    check("irq", 8'h01, {7'h00, irq});
    get(4'h0, 8'h04);
    get(4'h2, 8'h04);
    put(4'h3, 8'h00);
    idle(2);
    check("irq", 8'h00, {7'h00, irq});
    put(4'h2, 8'h04);
    get(4'h2, 8'h00);
    put(4'h0, 8'h07);
    get(4'h0, 8'h04);
    put(4'h0, 8'h03);
    get(4'h0, 8'h00);
    $display("test event done");
    second_low_voltage_threshold <= 1'h1;
    idle(6);
    get(4'h0, 8'h02);
    second_low_voltage_threshold <= 1'h0;
    idle(6);
    put(4'h0, 8'h06);
    get(4'h0, 8'h00);
    $display("test voltage done");
    por(1'h0);
    get(4'h0, 8'h07);
    $display("test second reset done");
    // software reinitialises after a data-loss read, then high-level events
    put(4'h0, 8'h00);
    get(4'h0, 8'h00);
    put(4'h1, 8'h01);
    event_input_pin <= 1'h1;
    idle(6);
    check("external_event_flag", 8'h01, {7'h00, external_event_flag});
    first_low_voltage_threshold <= 1'h1;
    idle(6);
    check("comp_stop", 8'h01, {7'h00, compensation_stop_voltage_flag});
    get(4'h2, 8'h05);
    put(4'h0, 8'h05);
    get(4'h0, 8'h04);
    check("data_loss", 8'h00, {7'h00, data_loss_voltage_flag});
    $display("test high level event done");
    conclude;
  end
endmodule

bind rtc_event_voltage_flags rtc_flags_asserts chk (.clk_sys, .rst_n, .addr, .wdata, .wr, .rd,
  .rdata, .event_input_pin, .second_low_voltage_threshold, .first_low_voltage_threshold,
  .external_event_flag, .data_loss_voltage_flag, .compensation_stop_voltage_flag,
  .init_done, .irq);
